// *** rtl/lie_params.svh ***
/*
  Offsets, field positions, reset values and timing counts of the
  interrupt-enable block. Assumes inclusion by bare name.
*/
`ifndef LIE_PARAMS_SVH
`define LIE_PARAMS_SVH

`define LIE_AW 12
`define LIE_OFS_SET 12'h000
`define LIE_OFS_CLR 12'h004
`define LIE_OFS_CTRL 12'h008
`define LIE_OFS_STAT 12'h00c
`define LIE_OFS_MASK 12'h010
`define LIE_OFS_STATE 12'h014

`define LIE_BIT_BRK 0
`define LIE_BIT_WAKE 1
`define LIE_BIT_LIN 0
`define LIE_BIT_SLEEP 1
`define LIE_BIT_WAKEREQ 2
`define LIE_BIT_BUSY 1

`define LIE_EN_RST 2'h0
`define LIE_MASK_RST 2'h0
`define LIE_CTRL_RST 1'h0
`define LIE_RDY_CYCLES 1

`endif

// *** rtl/lie_pkg.sv ***
/*
  Types shared by the interrupt-enable block.
  Assumes lie_params.svh for numeric constants.
*/
`default_nettype none
package lie_pkg;

  typedef enum logic {
    LIE_RUN = 1'b0,
    LIE_SLEEP = 1'b1
  } lie_power_t;

  // One bit per interrupt source, wake above break
  typedef struct packed {
    logic wake;
    logic brk;
  } lie_irq_vec_t;

endpackage : lie_pkg
`default_nettype wire

// *** rtl/lie_fall_detect.sv ***
/*
  Falling-edge detector for a level already synchronous to pclk.
  Assumes the input is clean and synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module lie_fall_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level_in,
  output logic fall
);

  logic prev_reg;

  // Idle high, so reset to 1 to avoid a false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign fall = prev_reg & ~level_in;

endmodule : lie_fall_detect
`default_nettype wire

// *** rtl/lie_sticky_status.sv ***
/*
  Sticky event flags, cleared bit by bit; a set in the clear cycle wins.
  Assumes clear holds only bits that software has already seen.
*/
`timescale 1ns/1ps
`default_nettype none
module lie_sticky_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire lie_pkg::lie_irq_vec_t set,
  input wire lie_pkg::lie_irq_vec_t clear,
  output lie_pkg::lie_irq_vec_t status
);

  lie_pkg::lie_irq_vec_t status_reg;
  lie_pkg::lie_irq_vec_t status_next;

  always_comb begin
    status_next = (status_reg & ~clear) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;

endmodule : lie_sticky_status
`default_nettype wire

// *** rtl/lie_irq_enable.sv ***
/*
  Interrupt-enable control for a LIN/UART-compatible serial module:
  set/clear enable registers, wake-up and break-detect interrupt
  generation, low-power state, sticky status, mask and one irq line.
  Assumes an APB master and inputs synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lie_params.svh"
module lie_irq_enable (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_receive_pin,
  input wire logic rx_busy,
  input wire logic wake_pulse,
  input wire logic break_detected,
  output logic irq,
  output logic low_power,
  output logic wake_event,
  output logic error_event
);

  // Address decode, shared by read capture and write
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  function automatic logic addr_valid(input logic [11:0] a);
    addr_valid = addr_hit(a, `LIE_OFS_SET) | addr_hit(a, `LIE_OFS_CLR) |
                 addr_hit(a, `LIE_OFS_CTRL) | addr_hit(a, `LIE_OFS_STAT) |
                 addr_hit(a, `LIE_OFS_MASK) | addr_hit(a, `LIE_OFS_STATE);
  endfunction : addr_valid

  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic wr_set;
  logic wr_clr;
  logic wr_ctrl;
  logic wr_mask;
  logic sleep_req;
  logic wake_req;

  lie_pkg::lie_irq_vec_t enable_reg;
  lie_pkg::lie_irq_vec_t enable_next;
  lie_pkg::lie_irq_vec_t mask_reg;
  lie_pkg::lie_irq_vec_t stat_cap_reg;
  lie_pkg::lie_irq_vec_t stat_clear;
  lie_pkg::lie_irq_vec_t events;
  lie_pkg::lie_irq_vec_t status;
  lie_pkg::lie_power_t power_reg;
  logic lin_mode_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_value;
  logic wake_fall;
  logic cause_fall;
  logic cause_busy;
  logic cause_low;
  logic wake_any;
  logic irq_reg;

  // Zero-wait slave: setup captures read data, access completes
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_valid(paddr);
  assign wr_acc = access_ph & pwrite;
  assign rd_acc = access_ph & ~pwrite;
  assign wr_set = wr_acc & addr_hit(paddr, `LIE_OFS_SET);
  assign wr_clr = wr_acc & addr_hit(paddr, `LIE_OFS_CLR);
  assign wr_ctrl = wr_acc & addr_hit(paddr, `LIE_OFS_CTRL);
  assign wr_mask = wr_acc & addr_hit(paddr, `LIE_OFS_MASK);
  assign sleep_req = wr_ctrl & pwdata[`LIE_BIT_SLEEP];
  assign wake_req = wr_ctrl & pwdata[`LIE_BIT_WAKEREQ];

  // One enable vector behind both views; bits 31-2 never stored
  always_comb begin
    enable_next = enable_reg;
    if (wr_set) begin
      enable_next = enable_next | lie_pkg::lie_irq_vec_t'(pwdata[1:0]);
    end
    if (wr_clr) begin
      enable_next = enable_next & ~lie_pkg::lie_irq_vec_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `LIE_EN_RST;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `LIE_MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= lie_pkg::lie_irq_vec_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_mode_reg <= `LIE_CTRL_RST;
    end else if (wr_ctrl) begin
      lin_mode_reg <= pwdata[`LIE_BIT_LIN];
    end
  end

  // Wake-up causes
  lie_fall_detect u_fall (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(wake_pulse),
    .fall(wake_fall)
  );

  // Pulse counts only in power-down
  assign cause_fall = (power_reg == lie_pkg::LIE_SLEEP) & wake_fall;
  assign cause_busy = (power_reg == lie_pkg::LIE_RUN) & sleep_req & rx_busy;
  assign cause_low = (power_reg == lie_pkg::LIE_SLEEP) & ~serial_receive_pin;
  assign wake_any = cause_fall | cause_busy | cause_low;

  // Wake enable ignores the mode; break enable only in UART mode
  always_comb begin
    events.wake = enable_reg.wake & wake_any;
    events.brk = enable_reg.brk & ~lin_mode_reg & break_detected;
  end

  // Low-power state; a busy receiver keeps the module running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_reg <= lie_pkg::LIE_RUN;
    end else begin
      unique case (power_reg)
        lie_pkg::LIE_RUN: begin
          if (sleep_req && !rx_busy) begin
            power_reg <= lie_pkg::LIE_SLEEP;
          end
        end
        lie_pkg::LIE_SLEEP: begin
          if (events.wake || wake_req) begin
            power_reg <= lie_pkg::LIE_RUN;
          end
        end
      endcase
    end
  end

  // Read data, captured in the setup cycle
  always_comb begin
    rd_value = 32'h0000_0000;
    if (addr_hit(paddr, `LIE_OFS_SET) || addr_hit(paddr, `LIE_OFS_CLR)) begin
      rd_value[1:0] = enable_reg;
    end else if (addr_hit(paddr, `LIE_OFS_CTRL)) begin
      rd_value[`LIE_BIT_LIN] = lin_mode_reg;
    end else if (addr_hit(paddr, `LIE_OFS_STAT)) begin
      rd_value[1:0] = status;
    end else if (addr_hit(paddr, `LIE_OFS_MASK)) begin
      rd_value[1:0] = mask_reg;
    end else if (addr_hit(paddr, `LIE_OFS_STATE)) begin
      rd_value[0] = power_reg;
      rd_value[`LIE_BIT_BUSY] = rx_busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= rd_value;
    end
  end

  // Remember exactly what was shown, so only seen bits are cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_cap_reg <= '0;
    end else if (setup_ph) begin
      stat_cap_reg <= (!pwrite && addr_hit(paddr, `LIE_OFS_STAT)) ? status : '0;
    end
  end

  assign stat_clear = (rd_acc && addr_hit(paddr, `LIE_OFS_STAT)) ? stat_cap_reg : '0;

  lie_sticky_status u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set(events),
    .clear(stat_clear),
    .status(status)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |((status & ~stat_clear | events) & mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign irq = irq_reg;
  assign low_power = (power_reg == lie_pkg::LIE_SLEEP);
  assign wake_event = events.wake;
  assign error_event = events.brk;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sleep_busy;
    sleep_req && rx_busy && !low_power && enable_reg.wake;
  endsequence

  sequence s_woken;
    status.wake && !low_power;
  endsequence

  sequence s_set_all;
    wr_set && pwdata[1:0] == 2'h3;
  endsequence

  sequence s_clear_all;
    wr_clr && pwdata[1:0] == 2'h3;
  endsequence

  a_rsvd_read_zero: assert property (
    rd_acc && (addr_hit(paddr, `LIE_OFS_SET) || addr_hit(paddr, `LIE_OFS_CLR))
    |-> prdata[31:2] == 30'h0)
    else $error("reserved enable bits read nonzero");

  a_read_enable: assert property (
    rd_acc && addr_hit(paddr, `LIE_OFS_SET) && !$past(wr_set || wr_clr)
    |-> prdata[1:0] == enable_reg)
    else $error("enable read does not match state");

  a_set_enables: assert property (
    wr_set && pwdata[`LIE_BIT_WAKE] && !wr_clr |=> enable_reg.wake)
    else $error("set-enable write did not enable");

  a_set_zero_keeps: assert property (
    wr_set && pwdata[1:0] == 2'h0 |=> $stable(enable_reg))
    else $error("set-enable write of zero changed state");

  a_clear_disables: assert property (
    wr_clr && pwdata[`LIE_BIT_BRK] |=> !enable_reg.brk)
    else $error("clear-enable write did not disable");

  a_shared_view: assert property (
    s_set_all ##[2:3] rd_acc && addr_hit(paddr, `LIE_OFS_CLR)
    |-> prdata[1:0] == 2'h3)
    else $error("clear view misses set write");

  a_brk_lin_blocked: assert property (
    lin_mode_reg |-> !error_event)
    else $error("break interrupt raised in LIN mode");

  a_brk_raises: assert property (
    break_detected && enable_reg.brk && !lin_mode_reg |=> status.brk)
    else $error("break detect missed in UART mode");

  a_wake_falling: assert property (
    low_power && wake_fall && enable_reg.wake |=> status.wake ##0 !low_power)
    else $error("wake pulse edge missed in sleep");

  a_wake_busy: assert property (
    s_sleep_busy |=> s_woken)
    else $error("sleep request while busy gave no wake");

  a_wake_low_rx: assert property (
    low_power && !serial_receive_pin && enable_reg.wake |-> wake_event ##1 !low_power)
    else $error("low receive level did not wake");

  a_no_wake_run: assert property (
    !low_power && !sleep_req |-> !wake_event)
    else $error("wake raised outside power-down");

  a_wake_mode_free: assert property (
    lin_mode_reg && low_power && wake_fall && enable_reg.wake |-> wake_event)
    else $error("wake blocked by LIN mode");

  a_shared_clear: assert property (
    s_clear_all ##[2:3] rd_acc && addr_hit(paddr, `LIE_OFS_SET) |-> prdata[1:0] == 2'h0)
    else $error("set view misses clear write");

  a_read_clear_view: assert property (
    rd_acc && addr_hit(paddr, `LIE_OFS_CLR) |-> prdata[1:0] == enable_reg)
    else $error("clear-enable read does not match state");

  a_clear_wake: assert property (
    wr_clr && pwdata[`LIE_BIT_WAKE] |=> !enable_reg.wake)
    else $error("clear-enable write kept wake enabled");

  a_clear_zero_keeps: assert property (
    wr_clr && pwdata[1:0] == 2'h0 |=> $stable(enable_reg))
    else $error("clear-enable write of zero changed state");

  a_set_brk: assert property (
    wr_set && pwdata[`LIE_BIT_BRK] |=> enable_reg.brk)
    else $error("set-enable write did not enable break");

  a_wake_off_sleeps: assert property (
    low_power && wake_fall && !enable_reg.wake && !wake_req |=> low_power)
    else $error("disabled wake left power-down");

  a_brk_off_quiet: assert property (
    break_detected && !enable_reg.brk && !status.brk |=> !status.brk)
    else $error("disabled break set status");

  a_status_sticky: assert property (
    status.brk && !stat_clear.brk |=> status.brk)
    else $error("break status lost without read");

  a_irq_brk: assert property (
    events.brk && mask_reg.brk |=> irq)
    else $error("unmasked break gave no irq");

  a_irq_wake: assert property (
    events.wake && mask_reg.wake |=> irq)
    else $error("unmasked wake gave no irq");

  a_irq_masked: assert property (
    mask_reg == 2'h0 |=> !irq)
    else $error("irq raised with all sources masked");

  a_sleep_enter: assert property (
    sleep_req && !rx_busy && !low_power |=> low_power)
    else $error("idle sleep request did not enter power-down");

  a_busy_stays: assert property (
    sleep_req && rx_busy && !low_power |=> !low_power)
    else $error("busy receiver entered power-down");

endmodule : lie_irq_enable
`default_nettype wire

// *** test/test_lin_interrupt_enable_set_clear.sv ***
/*
  Self-checking bench for the interrupt-enable block: APB register access,
  wake-up and break-detect events, status, mask and irq line.
  Assumes lie_params.svh on the include path and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lie_params.svh"
module test_lin_interrupt_enable_set_clear;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, serial_receive_pin, rx_busy, wake_pulse, break_detected;
  logic irq, low_power, wake_event, error_event;
  int error_cnt, tests_run;

  lie_irq_enable lie_irq_enable_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_receive_pin(serial_receive_pin),
    .rx_busy(rx_busy), .wake_pulse(wake_pulse), .break_detected(break_detected),
    .irq(irq), .low_power(low_power), .wake_event(wake_event), .error_event(error_event));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // One APB transfer; read data and error flag compared at the pready edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp, input logic experr);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      error_cnt++;
      test_done;
    end
    chk("pslverr", {31'h0, pslverr}, {31'h0, experr});
    chk("pready", {31'h0, pready}, 32'h1);
    if (!w) begin
      chk("prdata", prdata, exp);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, exp, 1'b0);
  endtask : rd

  // Kind 0 break, 1 wake pulse fall, 2 receive pin low; events seen mid-cycle
  task ev(input int k, input logic ew, input logic ee);
    @(posedge pclk);
    if (k == 0) begin
      break_detected <= 1'b1;
    end else if (k == 1) begin
      wake_pulse <= 1'b0;
    end else begin
      serial_receive_pin <= 1'b0;
    end
    @(negedge pclk);
    chk("wake_event", {31'h0, wake_event}, {31'h0, ew});
    chk("error_event", {31'h0, error_event}, {31'h0, ee});
    @(posedge pclk);
    break_detected <= 1'b0;
    wake_pulse <= 1'b1;
    serial_receive_pin <= 1'b1;
  endtask : ev

  task irq_is(input logic v);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, v});
  endtask : irq_is

  initial begin
    error_cnt = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    serial_receive_pin = 1'b1;
    rx_busy = 1'b0;
    wake_pulse = 1'b1;
    break_detected = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`LIE_OFS_SET, 32'h0);
    rd(`LIE_OFS_CLR, 32'h0);
    wr(`LIE_OFS_SET, 32'hffffffff);
    rd(`LIE_OFS_CLR, 32'h3);
    rd(`LIE_OFS_SET, 32'h3);
    wr(`LIE_OFS_SET, 32'h0);
    rd(`LIE_OFS_SET, 32'h3);
    wr(`LIE_OFS_CLR, 32'h1);
    rd(`LIE_OFS_SET, 32'h2);
    wr(`LIE_OFS_CLR, 32'h0);
    rd(`LIE_OFS_CLR, 32'h2);
    wr(`LIE_OFS_CLR, 32'h3);
    rd(`LIE_OFS_SET, 32'h0);
    wr(`LIE_OFS_SET, 32'h3);
    xfer(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    wr(`LIE_OFS_MASK, 32'h3);
    wr(`LIE_OFS_CTRL, 32'h0);
    ev(0, 1'b0, 1'b1);
    irq_is(1'b1);
    rd(`LIE_OFS_STAT, 32'h1);
    rd(`LIE_OFS_STAT, 32'h0);
    irq_is(1'b0);
    wr(`LIE_OFS_CLR, 32'h1);
    ev(0, 1'b0, 1'b0);
    wr(`LIE_OFS_SET, 32'h1);
    wr(`LIE_OFS_CTRL, 32'h1);
    ev(0, 1'b0, 1'b0);
    ev(1, 1'b0, 1'b0);
    rd(`LIE_OFS_STAT, 32'h0);
    wr(`LIE_OFS_CTRL, 32'h3);
    rd(`LIE_OFS_STATE, 32'h1);
    ev(1, 1'b1, 1'b0);
    rd(`LIE_OFS_STATE, 32'h0);
    chk("low_power", {31'h0, low_power}, 32'h0);
    rd(`LIE_OFS_STAT, 32'h2);
    wr(`LIE_OFS_CTRL, 32'h2);
    ev(2, 1'b1, 1'b0);
    rd(`LIE_OFS_STATE, 32'h0);
    rd(`LIE_OFS_STAT, 32'h2);
    rx_busy <= 1'b1;
    wr(`LIE_OFS_CTRL, 32'h2);
    rd(`LIE_OFS_STATE, 32'h2);
    rd(`LIE_OFS_STAT, 32'h2);
    rx_busy <= 1'b0;
    wr(`LIE_OFS_MASK, 32'h0);
    wr(`LIE_OFS_CTRL, 32'h2);
    ev(1, 1'b1, 1'b0);
    irq_is(1'b0);
    rd(`LIE_OFS_STAT, 32'h2);
    wr(`LIE_OFS_CLR, 32'h2);
    wr(`LIE_OFS_CTRL, 32'h2);
    ev(1, 1'b0, 1'b0);
    rd(`LIE_OFS_STATE, 32'h1);
    chk("low_power", {31'h0, low_power}, 32'h1);
    test_done;
  end
endmodule : test_lin_interrupt_enable_set_clear
`default_nettype wire
